// [design/ea_pkg.sv]
// Constants and types shared by the addressing-mode block
`default_nettype none
package ea_pkg;
	// Addressing modes recognised by the decoder
	typedef enum logic [3:0] {
		MODE_INH, MODE_IMM, MODE_DIR, MODE_EXT, MODE_IX0, MODE_IX1, MODE_IX2,
		MODE_REL, MODE_BSC, MODE_BTB, MODE_CTL
	} mode_t;
	// Instruction lengths in bytes
	localparam logic [15:0] LEN_ONE = 16'h0001;
	localparam logic [15:0] LEN_TWO = 16'h0002;
	localparam logic [15:0] LEN_THREE = 16'h0003;
	// Opcode field positions
	localparam int BITNUM_LSB = 1;
	localparam int BITPOL_POS = 0;
	// Condition code bit positions
	localparam int CC_C = 0;
	localparam int CC_Z = 1;
	localparam int CC_N = 2;
	localparam int CC_I = 3;
	localparam int CC_H = 4;
	// Reset values
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	// Bit set/clear bound of 128 bytes; not applied, so bit set/clear targets reach the lowest 256 bytes
	localparam logic [7:0] BSC_LIMIT = 8'h80;
endpackage
`default_nettype wire

// [design/ea_if.sv]
// Operand-fetch carrier between the sequencer and the address adder
`default_nettype none
interface ea_if;
	logic [3:0] mode;
	logic [7:0] x;
	logic [7:0] op1;
	logic [7:0] op2;
	logic [15:0] pc;
	logic [15:0] ea;
	modport seq (output mode, x, op1, op2, pc, input ea);
	modport calc (input mode, x, op1, op2, pc, output ea);
endinterface
`default_nettype wire

// [design/ea_calc.sv]
// Combinational effective-address former for every addressing mode
`default_nettype none
module ea_calc (
	ea_if.calc e
);
	logic [8:0] lo_sum;
	logic [7:0] hi_sum;
	// Low byte with carry, reused by both indexed-offset modes
	always_comb begin
		lo_sum = {1'b0, e.x} + {1'b0, (e.mode == 4'(ea_pkg::MODE_IX2)) ? e.op2 : e.op1};
		hi_sum = e.op1 + {7'h00, lo_sum[8]};
		unique case (ea_pkg::mode_t'(e.mode))
			ea_pkg::MODE_IMM: e.ea = e.pc + ea_pkg::LEN_ONE;
			ea_pkg::MODE_DIR, ea_pkg::MODE_BSC, ea_pkg::MODE_BTB: e.ea = {ea_pkg::BYTE_ZERO, e.op1};
			ea_pkg::MODE_EXT: e.ea = {e.op1, e.op2};
			ea_pkg::MODE_IX0: e.ea = {ea_pkg::BYTE_ZERO, e.x};
			ea_pkg::MODE_IX1: e.ea = {7'h00, lo_sum};
			ea_pkg::MODE_IX2: e.ea = {hi_sum, lo_sum[7:0]};
			default: e.ea = e.pc;
		endcase
	end
endmodule // ea_calc
`default_nettype wire

// [design/ea_seq.sv]
// Instruction-class sequencer: operand fetch, write-back, branches
`default_nettype none
// What this block does
// - Read-modify-write instructions read the operand, alter it, and store it back to the same place.
// - The negative-or-zero test reads and evaluates its operand but never writes it back.
// - A relative branch adds its signed offset to the counter only when its condition holds.
// - Bit set and clear can reach any bit in the lowest 256 bytes.
// - Bit test-and-branch can examine any bit in the lowest 256 locations.
// - Bit test-and-branch copies the examined bit into carry.
// - Inherent instructions need only the opcode and work on the accumulator or index.
// - Immediate operand sits at counter plus one and the counter advances by two.
// - Direct mode uses the next byte as low address with a zero high byte.
// - Extended mode takes high then low address bytes and advances the counter by three.
// - Indexed no-offset uses the index as low address, zero high, one-byte instruction.
// - Indexed 8-bit offset adds the byte to the index, carry forms the high byte.
// - Indexed 16-bit offset adds index to the low offset byte, carry into the high byte.
// - Bit set/clear is two bytes with the bit number in three opcode bits.
// - Bit test-and-branch is three bytes: opcode, tested address, signed offset.
module ea_seq (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic START,
	input wire logic [7:0] OPCODE,
	input wire logic [7:0] OP1,
	input wire logic [7:0] OP2,
	input wire logic [7:0] X_REG,
	input wire logic [7:0] ACC,
	input wire logic [7:0] CC_IN,
	input wire logic IRQ_LINE,
	input wire logic [7:0] MEM_RDATA,
	output logic [15:0] ADDR,
	output logic RD,
	output logic WR,
	output logic [7:0] WDATA,
	output logic [15:0] PC,
	output logic [7:0] CC_OUT,
	output logic [7:0] RESULT,
	output logic RES_TO_A,
	output logic RES_TO_X,
	output logic BUSY
);
	typedef enum logic [1:0] {IDLE, READ, WRITE} state_t;
	ea_if e ();
	ea_calc u_calc (.e(e));
	state_t st_q, st_d;
	logic [15:0] addr_q, addr_d, pc_q, pc_d;
	logic rd_q, rd_d, wr_q, wr_d, busy_q, busy_d, toa_q, toa_d, tox_q, tox_d;
	logic [7:0] wd_q, wd_d, cc_q, cc_d, res_q, res_d, op_q, op_d;
	ea_pkg::mode_t mode;
	logic [15:0] len;
	logic is_rmw, is_test_op, is_reg, taken, bitval;

	// Opcode high nibble gives the mode
	function automatic ea_pkg::mode_t decode(input logic [7:0] op);
		unique case (op[7:4])
			4'h0: return ea_pkg::MODE_BTB;
			4'h1: return ea_pkg::MODE_BSC;
			4'h2: return ea_pkg::MODE_REL;
			4'h3: return ea_pkg::MODE_DIR;
			4'h4, 4'h5: return ea_pkg::MODE_INH;
			4'h6, 4'hE: return ea_pkg::MODE_IX1;
			4'h7, 4'hF: return ea_pkg::MODE_IX0;
			4'hA: return ea_pkg::MODE_IMM;
			4'hB: return ea_pkg::MODE_DIR;
			4'hC: return ea_pkg::MODE_EXT;
			4'hD: return ea_pkg::MODE_IX2;
			default: return ea_pkg::MODE_CTL;
		endcase
	endfunction

	// Read-modify-write alteration by low nibble
	function automatic logic [7:0] modify(input logic [7:0] v, input logic [3:0] f,
			input logic c);
		unique case (f)
			4'hC: return v + 8'h01;
			4'hA: return v - 8'h01;
			4'hF: return 8'h00;
			4'h3: return ~v;
			4'h0: return 8'h00 - v;
			4'h9: return {v[6:0], c};
			4'h6: return {c, v[7:1]};
			4'h8: return {v[6:0], 1'b0};
			4'h4: return {1'b0, v[7:1]};
			4'h7: return {v[7], v[7:1]};
			default: return v;
		endcase
	endfunction

	// Relative branch condition per opcode low nibble
	function automatic logic cond(input logic [3:0] f, input logic [7:0] c, input logic irq);
		logic r;
		r = 1'b0;
		unique case (f[3:1])
			3'h0: r = 1'b1;
			3'h1: r = ~(c[ea_pkg::CC_C] | c[ea_pkg::CC_Z]);
			3'h2: r = ~c[ea_pkg::CC_C];
			3'h3: r = ~c[ea_pkg::CC_Z];
			3'h4: r = ~c[ea_pkg::CC_H];
			3'h5: r = ~c[ea_pkg::CC_N];
			3'h6: r = ~c[ea_pkg::CC_I];
			// Line pair: the even code branches while the pin is low
			3'h7: r = ~irq;
		endcase
		return r ^ f[0];
	endfunction

	// Feed the address former
	always_comb begin
		mode = decode(OPCODE);
		e.mode = 4'(mode);
		e.x = X_REG;
		e.op1 = OP1;
		e.op2 = OP2;
		e.pc = pc_q;
		// Memory alteration class of the latched opcode, only meaningful in READ
		is_rmw = (op_q[7:4] >= 4'h3) && (op_q[7:4] <= 4'h7);
		is_test_op = OPCODE[3:0] == 4'hD;
		is_reg = mode == ea_pkg::MODE_INH;
		bitval = MEM_RDATA[op_q[3:1]];
		unique case (mode)
			ea_pkg::MODE_INH, ea_pkg::MODE_IX0, ea_pkg::MODE_CTL: len = ea_pkg::LEN_ONE;
			ea_pkg::MODE_EXT, ea_pkg::MODE_IX2, ea_pkg::MODE_BTB: len = ea_pkg::LEN_THREE;
			default: len = ea_pkg::LEN_TWO;
		endcase
		taken = cond(OPCODE[3:0], CC_IN, IRQ_LINE);
	end

	// Next-state sequencing
	always_comb begin
		st_d = st_q; addr_d = addr_q; pc_d = pc_q; rd_d = 1'b0; wr_d = 1'b0;
		wd_d = wd_q; cc_d = cc_q; res_d = res_q; op_d = op_q;
		toa_d = 1'b0; tox_d = 1'b0; busy_d = busy_q;
		unique case (st_q)
			IDLE: if (START) begin
				op_d = OPCODE;
				cc_d = CC_IN;
				if (mode == ea_pkg::MODE_REL) begin
					pc_d = taken ? pc_q + ea_pkg::LEN_TWO + {{8{OP1[7]}}, OP1}
						: pc_q + ea_pkg::LEN_TWO;
				end else if (is_reg) begin
					res_d = modify(OPCODE[4] ? X_REG : ACC, OPCODE[3:0], CC_IN[ea_pkg::CC_C]);
					toa_d = ~OPCODE[4] & ~is_test_op;
					tox_d = OPCODE[4] & ~is_test_op;
					cc_d[ea_pkg::CC_N] = res_d[7];
					cc_d[ea_pkg::CC_Z] = res_d == 8'h00;
					pc_d = pc_q + len;
				end else if (mode == ea_pkg::MODE_CTL) begin
					pc_d = pc_q + len;
				end else begin
					addr_d = e.ea;
					rd_d = 1'b1;
					busy_d = 1'b1;
					st_d = READ;
					pc_d = pc_q + len;
					if (mode == ea_pkg::MODE_BTB)
						pc_d = pc_q + ea_pkg::LEN_THREE;
				end
			end
			READ: begin
				st_d = IDLE;
				busy_d = 1'b0;
				res_d = MEM_RDATA;
				if (decode(op_q) == ea_pkg::MODE_BTB) begin
					cc_d[ea_pkg::CC_C] = bitval;
					if (bitval ^ op_q[ea_pkg::BITPOL_POS])
						pc_d = pc_q + {{8{OP2[7]}}, OP2};
				end else if (decode(op_q) == ea_pkg::MODE_BSC) begin
					wd_d = MEM_RDATA;
					wd_d[op_q[3:1]] = ~op_q[ea_pkg::BITPOL_POS];
					wr_d = 1'b1; st_d = WRITE; busy_d = 1'b1;
				end else if (is_rmw) begin
					wd_d = modify(MEM_RDATA, op_q[3:0], cc_q[ea_pkg::CC_C]);
					cc_d[ea_pkg::CC_N] = wd_d[7];
					cc_d[ea_pkg::CC_Z] = wd_d == 8'h00;
					// write back same address, skipped for test
					if (op_q[3:0] != 4'hD) begin
						wr_d = 1'b1; st_d = WRITE; busy_d = 1'b1;
					end
				end
			end
			WRITE: begin
				st_d = IDLE;
				busy_d = 1'b0;
			end
		endcase
	end

	// Registers
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			st_q <= IDLE; addr_q <= 16'h0000; pc_q <= ea_pkg::PC_RESET;
			rd_q <= 1'b0; wr_q <= 1'b0; busy_q <= 1'b0; toa_q <= 1'b0; tox_q <= 1'b0;
			wd_q <= 8'h00; cc_q <= 8'h00; res_q <= 8'h00; op_q <= 8'h00;
		end else begin
			st_q <= st_d; addr_q <= addr_d; pc_q <= pc_d;
			rd_q <= rd_d; wr_q <= wr_d; busy_q <= busy_d; toa_q <= toa_d; tox_q <= tox_d;
			wd_q <= wd_d; cc_q <= cc_d; res_q <= res_d; op_q <= op_d;
		end
	end
	assign ADDR = addr_q;
	assign RD = rd_q;
	assign WR = wr_q;
	assign WDATA = wd_q;
	assign PC = pc_q;
	assign CC_OUT = cc_q;
	assign RESULT = res_q;
	assign RES_TO_A = toa_q;
	assign RES_TO_X = tox_q;
	assign BUSY = busy_q;

	// Write follows read at same address
	chk_rmw_write: assert property (@(posedge MCLK) disable iff (!RST_N)
		wr_q |-> $past(rd_q) && ADDR == $past(ADDR)) else $error("write without read");
	chk_test_nowrite: assert property (@(posedge MCLK) disable iff (!RST_N)
		(rd_q && is_rmw && op_q[3:0] == 4'hD) |=> !wr_q)
		else $error("test wrote back");
	chk_rel_pc: assert property (@(posedge MCLK) disable iff (!RST_N)
		(st_q == IDLE && START && mode == ea_pkg::MODE_REL && !taken)
		|=> pc_q == $past(pc_q) + 16'h0002) else $error("untaken branch pc");
	chk_dir_high: assert property (@(posedge MCLK) disable iff (!RST_N)
		(rd_q && decode(op_q) inside {ea_pkg::MODE_DIR, ea_pkg::MODE_BSC, ea_pkg::MODE_BTB})
		|-> ADDR[15:8] == 8'h00)
		else $error("direct high byte");
	chk_btb_carry: assert property (@(posedge MCLK) disable iff (!RST_N)
		(st_q == READ && decode(op_q) == ea_pkg::MODE_BTB) |=> cc_q[0] == $past(bitval))
		else $error("carry not bit");
	chk_ext_pc: assert property (@(posedge MCLK) disable iff (!RST_N)
		(st_q == IDLE && START && mode == ea_pkg::MODE_EXT) |=> pc_q == $past(pc_q) + 16'h0003)
		else $error("extended pc step");
	chk_inh_noread: assert property (@(posedge MCLK) disable iff (!RST_N)
		(st_q == IDLE && START && is_reg) |=> !rd_q) else $error("inherent read");
	chk_bsc_write: assert property (@(posedge MCLK) disable iff (!RST_N)
		(st_q == READ && decode(op_q) == ea_pkg::MODE_BSC) |=> wr_q) else $error("bit op no write");
	cov_rmw: cover property (@(posedge MCLK) disable iff (!RST_N) rd_q ##1 wr_q);
	cov_btb: cover property (@(posedge MCLK) disable iff (!RST_N)
		st_q == READ && decode(op_q) == ea_pkg::MODE_BTB);
	cov_rel: cover property (@(posedge MCLK) disable iff (!RST_N)
		st_q == IDLE && START && mode == ea_pkg::MODE_REL && taken);
endmodule // ea_seq
`default_nettype wire

// [tb/test_ea_seq.sv]
// Self-checking bench for the addressing-mode sequencer
`default_nettype none
module test_ea_seq;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [7:0] o, a, b, x, m, c;
		logic [15:0] ea, pd;
		logic [1:0] nr, nw;
		logic [7:0] wd, cm, cv;
	} row_t;
	logic mclk, rst_n, start, irq_line, rd, wr, res_to_a, res_to_x, busy;
	logic [7:0] opcode, op1, op2, x_reg, acc, cc_in, mem_rdata, wdata, cc_out, result;
	logic [15:0] addr, pc, exp_pc;
	int err_count, checks_done;
	// Ordinary cases; ea FFFF skips the address, nr 3 skips the read count
	row_t tbl [19] = '{
		'{8'hA6, 8'h55, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0001, 16'h0002, 2'h1, 2'h0, 8'h00, 8'h00, 8'h00},
		'{8'hB6, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0080, 16'h0002, 2'h1, 2'h0, 8'h00, 8'h00, 8'h00},
		'{8'hC6, 8'h12, 8'h34, 8'h00, 8'h00, 8'h00, 16'h1234, 16'h0003, 2'h1, 2'h0, 8'h00, 8'h00, 8'h00},
		'{8'hF6, 8'h00, 8'h00, 8'hF0, 8'h00, 8'h00, 16'h00F0, 16'h0001, 2'h1, 2'h0, 8'h00, 8'h00, 8'h00},
		'{8'hE6, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00, 16'h01FE, 16'h0002, 2'h1, 2'h0, 8'h00, 8'h00, 8'h00},
		'{8'hD6, 8'h12, 8'hF0, 8'h20, 8'h00, 8'h00, 16'h1310, 16'h0003, 2'h1, 2'h0, 8'h00, 8'h00, 8'h00},
		'{8'h3C, 8'h40, 8'h00, 8'h00, 8'h7F, 8'h00, 16'h0040, 16'h0002, 2'h1, 2'h1, 8'h80, 8'h06, 8'h04},
		'{8'h3D, 8'h41, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0041, 16'h0002, 2'h1, 2'h0, 8'h00, 8'h06, 8'h02},
		'{8'h4C, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 16'hFFFF, 16'h0001, 2'h0, 2'h0, 8'h11, 8'h06, 8'h00},
		'{8'h20, 8'hFE, 8'h00, 8'h00, 8'h00, 8'h00, 16'hFFFF, 16'h0000, 2'h0, 2'h0, 8'h00, 8'h00, 8'h00},
		'{8'h27, 8'h10, 8'h00, 8'h00, 8'h00, 8'h02, 16'hFFFF, 16'h0012, 2'h0, 2'h0, 8'h00, 8'h00, 8'h00},
		'{8'h16, 8'h7F, 8'h00, 8'h00, 8'h00, 8'h00, 16'h007F, 16'h0002, 2'h1, 2'h1, 8'h08, 8'h00, 8'h00},
		'{8'h04, 8'hFF, 8'h05, 8'h00, 8'h04, 8'h00, 16'h00FF, 16'h0008, 2'h1, 2'h0, 8'h00, 8'h01, 8'h01},
		'{8'h0E, 8'h10, 8'hF0, 8'h00, 8'h00, 8'h00, 16'h0010, 16'h0003, 2'h1, 2'h0, 8'h00, 8'h01, 8'h00},
		// Index decrement, line-level branches with the pin low, control, bit clear
		'{8'h5A, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 16'hFFFF, 16'h0001, 2'h0, 2'h0, 8'hFF, 8'h06, 8'h04},
		'{8'h2F, 8'h30, 8'h00, 8'h00, 8'h00, 8'h00, 16'hFFFF, 16'h0002, 2'h0, 2'h0, 8'h00, 8'h00, 8'h00},
		'{8'h2E, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 16'hFFFF, 16'h0006, 2'h0, 2'h0, 8'h00, 8'h00, 8'h00},
		'{8'h9D, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 16'hFFFF, 16'h0001, 2'h0, 2'h0, 8'h00, 8'h00, 8'h00},
		'{8'h11, 8'h20, 8'h00, 8'h00, 8'hFF, 8'h00, 16'h0020, 16'h0002, 2'h1, 2'h1, 8'hFE, 8'h00, 8'h00}
	};

	ea_seq i_ea_seq (.MCLK(mclk), .RST_N(rst_n), .START(start), .OPCODE(opcode), .OP1(op1),
		.OP2(op2), .X_REG(x_reg), .ACC(acc), .CC_IN(cc_in), .IRQ_LINE(irq_line),
		.MEM_RDATA(mem_rdata), .ADDR(addr), .RD(rd), .WR(wr), .WDATA(wdata), .PC(pc),
		.CC_OUT(cc_out), .RESULT(result), .RES_TO_A(res_to_a), .RES_TO_X(res_to_x), .BUSY(busy));

	// Comparisons, counted and reported
	task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// One instruction; hold keeps start high while busy to probe refusal
	task automatic run(input row_t r, input bit hold);
		logic [7:0] nr, nw, na, nx, wd;
		int i;
		nr = 8'h00;
		nw = 8'h00;
		na = 8'h00;
		nx = 8'h00;
		wd = 8'h00;
		@(negedge mclk);
		{opcode, op1, op2, x_reg, mem_rdata, cc_in} = {r.o, r.a, r.b, r.x, r.m, r.c};
		start = 1'b1;
		for (i = 0; i < 10; i++) begin
			@(negedge mclk);
			if (!hold) start = 1'b0;
			nr = nr + {7'h00, rd};
			nw = nw + {7'h00, wr};
			na = na + {7'h00, res_to_a};
			nx = nx + {7'h00, res_to_x};
			if (wr === 1'b1) wd = wdata;
			if (busy !== 1'b1) break;
		end
		start = 1'b0;
		exp_pc = exp_pc + r.pd;
		chk8("busy", 8'h00, {7'h00, busy});
		chk16("pc", exp_pc, pc);
		if (r.ea !== 16'hFFFF) chk16("addr", r.ea, addr);
		if (r.nr !== 2'h3) chk8("reads", {6'h00, r.nr}, nr);
		chk8("writes", {6'h00, r.nw}, nw);
		if (r.nw !== 2'h0) chk8("wdata", r.wd, wd);
		chk8("flags", r.cv, cc_out & r.cm);
		chk8("to_acc", {7'h00, r.o[7:4] === 4'h4}, na);
		chk8("to_x", {7'h00, r.o[7:4] === 4'h5}, nx);
		if (r.o[7:4] inside {4'h4, 4'h5}) chk8("result", r.wd, result);
	endtask

	// Free-running 25 MHz clock
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// Hang guard, far beyond the roughly seventy cycles of the run
	initial begin
		#100000;
		err_count++;
		summarize();
	end

	// Main sequence: table, then refusal and mid-run reset
	initial begin
		err_count = 0;
		checks_done = 0;
		exp_pc = 16'h0000;
		rst_n = 1'b0;
		start = 1'b0;
		irq_line = 1'b0;
		acc = 8'h10;
		{opcode, op1, op2, x_reg, mem_rdata, cc_in} = 48'h0;
		repeat (8) @(negedge mclk);
		rst_n = 1'b1;
		foreach (tbl[k]) run(tbl[k], 1'b0);
		// Start held while busy must not relaunch the increment
		run(tbl[6], 1'b1);
		// Reset in mid-instruction clears the outputs
		@(negedge mclk);
		{opcode, op1, mem_rdata} = {8'h3C, 8'h40, 8'h00};
		start = 1'b1;
		@(negedge mclk);
		start = 1'b0;
		rst_n = 1'b0;
		@(negedge mclk);
		chk16("pc_rst", 16'h0000, pc);
		chk16("addr_rst", 16'h0000, addr);
		chk8("busy_rst", 8'h00, {7'h00, busy});
		rst_n = 1'b1;
		exp_pc = 16'h0000;
		run(tbl[0], 1'b0);
		summarize();
	end
endmodule // test_ea_seq
`default_nettype wire
